// >>> rtl/rbt_pkg.sv
// package: constants, register map and control carrier type of the registered bus transceiver
package rbt_pkg;
   localparam int DATA_W = 16;
   localparam int FIFO_DEPTH = 4;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_A_STORE = 8'h08;
   localparam logic [7:0] OFS_B_STORE = 8'h0C;
   localparam logic [7:0] OFS_FIFO_DATA = 8'h10;
   localparam int CTRL_SNAP_EN_BIT = 0;
   localparam int STAT_EMPTY_BIT = 0;
   localparam int STAT_FULL_BIT = 1;
   localparam int STAT_OVF_BIT = 2;
   localparam logic RST_SNAP_EN = 1'b0;
   localparam logic RST_OVF = 1'b0;
   localparam logic RST_CLK_PREV = 1'b1;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HRESP_OKAY = 2'h0;

   typedef struct packed {
      logic oe_n;
      logic dir;
      logic a_side_capture_clock;
      logic b_side_capture_clock;
      logic a_drive_source_select;
      logic b_drive_source_select;
   } rbt_ctl_s;
endpackage : rbt_pkg

// >>> rtl/rbt_transceiver.sv
// registered bus transceiver: snapshot fifo and top level with ahb-lite slave
//
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module rbt_fifo #(
   parameter int W = 16,
   parameter int D = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0] cnt_reg;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;
   wire [AW-1:0] wr_inc = (wr_reg == AW'(D - 1)) ? '0 : wr_reg + 1'b1;
   wire [AW-1:0] rd_inc = (rd_reg == AW'(D - 1)) ? '0 : rd_reg + 1'b1;
   assign in_ready = (cnt_reg != (AW + 1)'(D));
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem[rd_reg];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) wr_reg <= wr_inc;
         if (pop) rd_reg <= rd_inc;
         cnt_reg <= cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end

   // the count must track pushes and pops exactly, or the full flag would let a snapshot overwrite the head
   a_fifo_bound: assert property (@(posedge clk) disable iff (!rst_n) cnt_reg <= (AW + 1)'(D))
      else $error("queue count above depth");
   a_fifo_step: assert property (@(posedge clk) disable iff (!rst_n)
      push && !pop |=> cnt_reg == $past(cnt_reg) + 1'b1)
      else $error("queue count missed a push");
   a_fifo_drain: assert property (@(posedge clk) disable iff (!rst_n)
      pop && !push |=> cnt_reg == $past(cnt_reg) - 1'b1)
      else $error("queue count missed a pop");
   a_fifo_flags: assert property (@(posedge clk) disable iff (!rst_n) in_ready || out_valid)
      else $error("queue both full and empty");
   a_fifo_head_held: assert property (@(posedge clk) disable iff (!rst_n)
      out_valid && !pop |=> out_data == $past(out_data))
      else $error("queue head moved without a pop");
   a_fifo_stay_empty: assert property (@(posedge clk) disable iff (!rst_n)
      !out_valid && !push |=> !out_valid)
      else $error("queue filled without a push");
endmodule : rbt_fifo

// Function
// - a 16-bit path joins the A and B buses with one store per direction and a driver on each bus.
// - each store loads its source bus on the rising edge of its own capture clock.
// - loading ignores output enable and direction and happens even while that bus is driven.
// - with output enable high neither bus is driven.
// - in isolation either capture clock or both may be pulsed and the stores load accordingly.
// - with outputs enabled only the bus chosen by direction is driven and the other stays an input.
// - direction low drives the A bus, direction high drives the B bus, while output enable is low.
// - A-side select low drives the A bus with the live B value.
// - A-side select high drives the A bus with the B store.
// - B-side select low drives the B bus with the live A value.
// - B-side select high drives the B bus with the A store.
// - the A and B buses are never driven together.
module rbt_transceiver #(
   parameter int W = rbt_pkg::DATA_W,
   parameter int DEPTH = rbt_pkg::FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire rbt_pkg::rbt_ctl_s ctl,
   input wire logic [W-1:0] a_in,
   output logic [W-1:0] a_out,
   output logic a_oe,
   input wire logic [W-1:0] b_in,
   output logic [W-1:0] b_out,
   output logic b_oe,
   output logic snap_ready,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [1:0] hresp,
   output logic [31:0] hrdata
);
   // stores carry no reset: contents are unknown until the first capture
   logic [W-1:0] a_store_reg;
   logic [W-1:0] b_store_reg;
   logic a_clk_prev_reg;
   logic b_clk_prev_reg;
   logic snap_en_reg;
   logic ovf_reg;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic [31:0] hrdata_reg;
   logic fifo_valid;
   logic [W-1:0] fifo_data;

   // edge detection on the capture pins; prev resets high so a pin held high at release is no edge
   wire a_edge = ctl.a_side_capture_clock & ~a_clk_prev_reg;
   wire b_edge = ctl.b_side_capture_clock & ~b_clk_prev_reg;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         a_clk_prev_reg <= rbt_pkg::RST_CLK_PREV;
         b_clk_prev_reg <= rbt_pkg::RST_CLK_PREV;
      end else begin
         a_clk_prev_reg <= ctl.a_side_capture_clock;
         b_clk_prev_reg <= ctl.b_side_capture_clock;
      end
   end

   // loads depend on the capture edge only, never on oe_n or dir
   always_ff @(posedge clk) begin
      if (a_edge) a_store_reg <= a_in;
      if (b_edge) b_store_reg <= b_in;
   end

   // driver enables are exclusive by construction of dir
   wire out_en = ~ctl.oe_n;
   assign a_oe = out_en & ~ctl.dir;
   assign b_oe = out_en & ctl.dir;
   // live paths are combinational, so the bus follows the far side with no clock
   assign a_out = ctl.a_drive_source_select ? b_store_reg : b_in;
   assign b_out = ctl.b_drive_source_select ? a_store_reg : a_in;

   // each A capture is also queued for software when snapshots are on and the queue is not full
   wire snap_push = a_edge & snap_en_reg;
   wire snap_lost = snap_push & ~snap_ready;

   // ahb-lite: zero wait states, always okay
   wire addr_ok = hsel & htrans[1] & hready;
   wire rd_take = addr_ok & ~hwrite;
   wire wr_take = addr_ok & hwrite;
   wire [7:0] a_ofs = haddr[7:0];
   wire hit_hi = (haddr[31:8] == 24'h000000);
   wire rd_fifo = rd_take & hit_hi & (a_ofs == rbt_pkg::OFS_FIFO_DATA);
   wire wr_ctrl = wr_pend_reg & (wr_addr_reg == rbt_pkg::OFS_CTRL);
   wire wr_stat = wr_pend_reg & (wr_addr_reg == rbt_pkg::OFS_STATUS);
   wire ovf_clr = wr_stat & hwdata[rbt_pkg::STAT_OVF_BIT];
   wire [31:0] stat_word = {29'h0, ovf_reg, ~snap_ready, ~fifo_valid};
   wire [31:0] rd_mux =
      !hit_hi ? 32'h0 :
      (a_ofs == rbt_pkg::OFS_CTRL) ? {31'h0, snap_en_reg} :
      (a_ofs == rbt_pkg::OFS_STATUS) ? stat_word :
      (a_ofs == rbt_pkg::OFS_A_STORE) ? 32'(a_store_reg) :
      (a_ofs == rbt_pkg::OFS_B_STORE) ? 32'(b_store_reg) :
      (a_ofs == rbt_pkg::OFS_FIFO_DATA) ? 32'(fifo_data) : 32'h0;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hrdata_reg <= 32'h0;
      end else begin
         if (hready) wr_pend_reg <= wr_take & hit_hi;
         if (wr_take) wr_addr_reg <= a_ofs;
         if (rd_take) hrdata_reg <= rd_mux;
      end
   end

   // overflow: a new loss in the clearing cycle wins over the clear
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         snap_en_reg <= rbt_pkg::RST_SNAP_EN;
         ovf_reg <= rbt_pkg::RST_OVF;
      end else begin
         if (wr_ctrl) snap_en_reg <= hwdata[rbt_pkg::CTRL_SNAP_EN_BIT];
         ovf_reg <= snap_lost | (ovf_reg & ~ovf_clr);
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = rbt_pkg::HRESP_OKAY;
   assign hrdata = hrdata_reg;

   rbt_fifo #(
      .W(W),
      .D(DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(snap_push),
      .in_ready(snap_ready),
      .in_data(a_in),
      .out_valid(fifo_valid),
      .out_ready(rd_fifo),
      .out_data(fifo_data)
   );

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_one_driver: assert property (!(a_oe && b_oe))
      else $error("both buses driven");
   a_isolation_quiet: assert property (ctl.oe_n |-> (!a_oe && !b_oe))
      else $error("driver on in isolation");
   a_dir_choice: assert property (!ctl.oe_n |-> (b_oe == ctl.dir) && (a_oe != ctl.dir))
      else $error("wrong bus driven for dir");
   a_a_live: assert property (a_oe && !ctl.a_drive_source_select |-> a_out == b_in)
      else $error("A bus not live B");
   a_a_stored: assert property (a_oe && ctl.a_drive_source_select && !b_edge |=>
      (!a_oe || !ctl.a_drive_source_select || a_out == $past(b_store_reg)))
      else $error("A bus not stored B");
   a_b_live: assert property (b_oe && !ctl.b_drive_source_select |-> b_out == a_in)
      else $error("B bus not live A");
   a_b_stored: assert property (b_oe && ctl.b_drive_source_select && !a_edge |=>
      (!b_oe || !ctl.b_drive_source_select || b_out == $past(a_store_reg)))
      else $error("B bus not stored A");
   a_a_capture: assert property (a_edge |=> a_store_reg == $past(a_in))
      else $error("A store missed capture");
   a_b_capture: assert property (b_edge |=> b_store_reg == $past(b_in))
      else $error("B store missed capture");
   a_hold_store: assert property (!a_edge && !b_edge |=>
      $stable(a_store_reg) && $stable(b_store_reg))
      else $error("store changed without edge");
   a_ovf_sticky: assert property (snap_lost |=> ovf_reg)
      else $error("overflow not held");

   // the edge detectors must follow the pins one cycle late, else a held pin would capture twice
   a_a_prev_track: assert property (1'b1 |=> a_clk_prev_reg == $past(ctl.a_side_capture_clock))
      else $error("A edge detector lost the pin");
   a_b_prev_track: assert property (1'b1 |=> b_clk_prev_reg == $past(ctl.b_side_capture_clock))
      else $error("B edge detector lost the pin");
   a_iso_store_a: assert property (ctl.oe_n && a_edge |=> a_store_reg == $past(a_in))
      else $error("A store missed isolated capture");
   a_iso_store_b: assert property (ctl.oe_n && b_edge |=> b_store_reg == $past(b_in))
      else $error("B store missed isolated capture");
   a_drive_store_a: assert property (!ctl.oe_n && a_edge |=> a_store_reg == $past(a_in))
      else $error("A store missed capture while driving");
   a_drive_store_b: assert property (!ctl.oe_n && b_edge |=> b_store_reg == $past(b_in))
      else $error("B store missed capture while driving");
   a_oe_one_on: assert property (!ctl.oe_n |-> (a_oe != b_oe))
      else $error("enabled outputs drive no bus");
   a_b_oe_dir: assert property (b_oe |-> ctl.dir && !ctl.oe_n)
      else $error("B bus driven outside its mode");

   // register bus: never stalls, never errors, read data stands until the next read
   a_ahb_no_wait: assert property (hreadyout)
      else $error("slave inserted a wait state");
   a_ahb_okay: assert property (hresp == rbt_pkg::HRESP_OKAY)
      else $error("slave answered with an error");
   a_rd_data_held: assert property (!rd_take |=> $stable(hrdata))
      else $error("read data moved outside a read");
   a_oob_read_zero: assert property (rd_take && !hit_hi |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_status_read: assert property (rd_take && hit_hi && a_ofs == rbt_pkg::OFS_STATUS |=>
      hrdata == $past(stat_word))
      else $error("status read wrong");
   a_ctrl_read: assert property (rd_take && hit_hi && a_ofs == rbt_pkg::OFS_CTRL |=>
      hrdata == {31'h0, $past(snap_en_reg)})
      else $error("control read wrong");
   a_ctrl_write: assert property (wr_ctrl |=> snap_en_reg == $past(hwdata[rbt_pkg::CTRL_SNAP_EN_BIT]))
      else $error("control write lost");
   a_ctrl_held: assert property (!wr_ctrl |=> $stable(snap_en_reg))
      else $error("control changed without a write");

   // snapshot queue and its sticky loss flag; a loss in the clearing cycle must survive
   a_fifo_pop: assert property (rd_fifo && fifo_valid |=> hrdata == 32'($past(fifo_data)))
      else $error("queue read returned wrong word");
   a_snap_accept: assert property (snap_push && snap_ready |=> fifo_valid)
      else $error("snapshot not queued");
   a_push_data: assert property (snap_push && snap_ready && !fifo_valid |=> fifo_data == $past(a_in))
      else $error("queued snapshot has wrong data");
   a_ovf_clears: assert property (ovf_clr && !snap_lost |=> !ovf_reg)
      else $error("overflow not cleared");
   a_ovf_holds: assert property (ovf_reg && !ovf_clr |=> ovf_reg)
      else $error("overflow dropped without a clear");
   a_ovf_quiet: assert property (!snap_lost && !ovf_reg |=> !ovf_reg)
      else $error("overflow set without a loss");

   c_iso_both: cover property (ctl.oe_n && a_edge && b_edge);
   c_stored_a_to_b: cover property (b_oe && ctl.b_drive_source_select);
   c_stored_b_to_a: cover property (a_oe && ctl.a_drive_source_select);
   c_fifo_full: cover property (!snap_ready ##1 rd_fifo);
   c_live_b_to_a: cover property (a_oe && !ctl.a_drive_source_select);
endmodule : rbt_transceiver

// >>> sim/rbt_bus_model.sv
// bus model: outside logic on the A and B buses, resolving each wire
`timescale 1ns/1ps
module rbt_bus_model (
   input wire logic a_oe,
   input wire logic [15:0] a_out,
   input wire logic [15:0] a_drv,
   input wire logic b_oe,
   input wire logic [15:0] b_out,
   input wire logic [15:0] b_drv,
   output logic [15:0] a_in,
   output logic [15:0] b_in
);
   // outside logic drives a bus only while the device leaves it an input
   assign a_in = a_oe ? a_out : a_drv;
   assign b_in = b_oe ? b_out : b_drv;
endmodule : rbt_bus_model

// >>> sim/registered_bus_transceiver16_tb.sv
// testbench: bus modes, captures, snapshot fifo over ahb-lite
`timescale 1ns/1ps
module registered_bus_transceiver16_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   rbt_pkg::rbt_ctl_s ctl = rbt_pkg::rbt_ctl_s'(6'h20);
   logic [15:0] a_drv = 16'hA5C3;
   logic [15:0] b_drv = 16'h3C5A;
   logic [15:0] a_in, b_in, a_out, b_out;
   logic a_oe, b_oe, snap_ready, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [1:0] htrans = 2'h0;
   logic [1:0] hresp;
   logic [2:0] hsize = 3'h2;
   int fail_count = 0;
   int checks = 0;
   assign hready = hreadyout;
   always #25 clk = ~clk;
   rbt_bus_model u_bus (.a_oe(a_oe), .a_out(a_out), .a_drv(a_drv), .b_oe(b_oe), .b_out(b_out), .b_drv(b_drv),
      .a_in(a_in), .b_in(b_in));
   rbt_transceiver u_dut (.clk(clk), .rst_n(rst_n), .ctl(ctl), .a_in(a_in), .a_out(a_out), .a_oe(a_oe),
      .b_in(b_in), .b_out(b_out), .b_oe(b_oe), .snap_ready(snap_ready), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic close_out;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out
   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 16);
      if (hready !== 1'b1) begin
         fail_count++;
         close_out();
      end
   endtask : wait_ready
   task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= rbt_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      haddr <= {24'h0, adr};
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
      chk({30'h0, hresp}, {30'h0, rbt_pkg::HRESP_OKAY});
   endtask : bus
   task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] d;
      bus(1'b0, adr, 32'h0, d);
      chk(d, exp);
   endtask : rchk
   // pin high for one sample, then low: exactly one capture
   task automatic cap(input logic a, input logic b);
      ctl.a_side_capture_clock <= a;
      ctl.b_side_capture_clock <= b;
      @(posedge clk);
      ctl.a_side_capture_clock <= 1'b0;
      ctl.b_side_capture_clock <= 1'b0;
      @(posedge clk);
   endtask : cap
   task automatic mode(input logic oe_n, input logic dir, input logic asel, input logic bsel);
      ctl.oe_n <= oe_n;
      ctl.dir <= dir;
      ctl.a_drive_source_select <= asel;
      ctl.b_drive_source_select <= bsel;
      @(posedge clk);
      #1;
   endtask : mode
   task automatic s_isolate;
      logic [31:0] d;
      cap(1'b1, 1'b1);
      chk({a_oe, b_oe}, 32'h0);
      rchk(rbt_pkg::OFS_A_STORE, 32'hA5C3);
      rchk(rbt_pkg::OFS_B_STORE, 32'h3C5A);
      a_drv <= 16'h0FF0;
      b_drv <= 16'hF00F;
      cap(1'b1, 1'b0);
      rchk(rbt_pkg::OFS_A_STORE, 32'h0FF0);
      rchk(rbt_pkg::OFS_B_STORE, 32'h3C5A);
      bus(1'b1, rbt_pkg::OFS_A_STORE, 32'h1234, d);
      rchk(rbt_pkg::OFS_A_STORE, 32'h0FF0);
   endtask : s_isolate
   task automatic s_drive;
      mode(1'b0, 1'b1, 1'b0, 1'b0);
      chk({b_oe, a_oe, b_out}, {16'h2, a_drv});
      a_drv <= 16'h8001;
      #1;
      chk({16'h0, b_out}, 32'h8001);
      mode(1'b0, 1'b1, 1'b0, 1'b1);
      chk({16'h0, b_out}, 32'h0FF0);
      mode(1'b0, 1'b0, 1'b0, 1'b1);
      chk({a_oe, b_oe, a_out}, {16'h2, b_drv});
      mode(1'b0, 1'b0, 1'b1, 1'b1);
      chk({16'h0, a_out}, 32'h3C5A);
      mode(1'b0, 1'b0, 1'b0, 1'b0);
      cap(1'b1, 1'b1);
      rchk(rbt_pkg::OFS_A_STORE, {16'h0, b_drv});
      rchk(rbt_pkg::OFS_B_STORE, {16'h0, b_drv});
   endtask : s_drive
   task automatic s_fifo;
      logic [31:0] d;
      mode(1'b1, 1'b0, 1'b0, 1'b0);
      bus(1'b1, rbt_pkg::OFS_CTRL, 32'h1, d);
      for (int i = 0; i < 5; i++) begin
         a_drv <= 16'h1000 + 16'(i);
         cap(1'b1, 1'b0);
      end
      chk({31'h0, snap_ready}, 32'h0);
      rchk(rbt_pkg::OFS_STATUS, 32'h6);
      for (int i = 0; i < 4; i++) begin
         rchk(rbt_pkg::OFS_FIFO_DATA, 32'h1000 + i);
      end
      rchk(rbt_pkg::OFS_STATUS, 32'h5);
      bus(1'b1, rbt_pkg::OFS_STATUS, 32'h4, d);
      rchk(rbt_pkg::OFS_STATUS, 32'h1);
      rchk(8'h20, 32'h0);
   endtask : s_fifo
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rchk(rbt_pkg::OFS_STATUS, 32'h1);
      rchk(rbt_pkg::OFS_CTRL, 32'h0);
      s_isolate();
      s_drive();
      s_fifo();
      close_out();
   end
endmodule : registered_bus_transceiver16_tb
